// file: core/sadc_consts.svh
// Register word indices, field positions, reset values and timing counts of the converter sequencer
`ifndef SADC_CONSTS_SVH
`define SADC_CONSTS_SVH

`define SADC_IDX_CONTROL 4'hE
`define SADC_IDX_TIMING 4'hF
`define SADC_IDX_RES_UPPER 4'h0
`define SADC_IDX_RES_LOWER 4'h1
`define SADC_IDX_SAMPLE 4'h2
`define SADC_IDX_POWER 4'h3

`define SADC_CTL_START 7
`define SADC_CTL_MODE_HI 6
`define SADC_CTL_MODE_LO 5
`define SADC_CTL_INDIS 4
`define SADC_CTL_CHAN_HI 3
`define SADC_CTL_CHAN_LO 0
`define SADC_TIM_LADDER 5
`define SADC_TIM_TIME_HI 3
`define SADC_TIM_TIME_LO 1
`define SADC_LOW_DONE 5
`define SADC_LOW_BUSY 4

`define SADC_CONTROL_RST 8'h10
`define SADC_TIMING_RST 6'h00
`define SADC_TIMING_FIXED 8'h10

`define SADC_CYC_39 16'd39
`define SADC_CYC_78 16'd78
`define SADC_CYC_156 16'd156
`define SADC_CYC_312 16'd312
`define SADC_CYC_624 16'd624
`define SADC_CYC_1248 16'd1248

`endif

// file: core/sadc_pkg.sv
// Types shared by the converter sequencer modules
package sadc_pkg;
  typedef enum logic [1:0] {
    SADC_MODE_OFF,
    SADC_MODE_SINGLE,
    SADC_MODE_RSVD,
    SADC_MODE_REPEAT
  } sadc_mode_e;

  typedef enum logic [1:0] {
    SADC_ST_IDLE,
    SADC_ST_CONV,
    SADC_ST_STORE
  } sadc_state_e;

  typedef logic [9:0] sadc_result_t;
endpackage

// file: core/sadc_time_dec.sv
// Conversion time code to cycle count decoder
`timescale 1ns/1ps
`include "sadc_consts.svh"
module sadc_time_dec (
  input wire logic [2:0] code_i,
  output logic [15:0] cycles_o,
  output logic valid_o
);
  import sadc_pkg::*;
  always_comb begin
    valid_o = 1'b1;
    case (code_i)
      3'h0: cycles_o = `SADC_CYC_39;
      3'h2: cycles_o = `SADC_CYC_78;
      3'h3: cycles_o = `SADC_CYC_156;
      3'h4: cycles_o = `SADC_CYC_312;
      3'h5: cycles_o = `SADC_CYC_624;
      3'h6: cycles_o = `SADC_CYC_1248;
      default: begin
        cycles_o = `SADC_CYC_1248;
        valid_o = 1'b0;
      end
    endcase
  end
endmodule

// file: core/sadc_timer.sv
// Conversion length down counter
`timescale 1ns/1ps
module sadc_timer #(
  parameter int W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic abort_i,
  input wire logic [W-1:0] len_i,
  output logic expire_o
);
  logic [W-1:0] cnt_q;
  logic run_q;
  if (W < 11) begin : g_width_check
    $error("Timer width too small for longest conversion");
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || abort_i) begin
      run_q <= 1'b0;
      cnt_q <= '0;
    end else if (load_i) begin
      run_q <= 1'b1;
      cnt_q <= len_i - W'(2);
    end else if (run_q) begin
      if (cnt_q == '0) begin
        run_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q - W'(1);
      end
    end
  end
  assign expire_o = run_q && (cnt_q == '0) && !load_i && !abort_i;
endmodule

// file: core/sadc_top.sv
// Successive approximation converter sequencer with Wishbone register slave
//
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ps
`include "sadc_consts.svh"
module sadc_top #(
  parameter int CHAN_N = 8,
  parameter int TIMER_W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic low_power_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic [sadc_pkg::sadc_result_t'($bits(sadc_pkg::sadc_result_t))-1:0] sample_data_i,
  output logic sample_req_o,
  output logic [2:0] channel_o,
  output logic input_disable_o,
  output logic ladder_on_o,
  output logic conv_done_irq_o,
  output logic conv_busy_o
);
  import sadc_pkg::*;

  // Parameter ranges the logic can serve
  if (CHAN_N < 1 || CHAN_N > 8) begin : g_chan_check
    $error("Channel count must lie between 1 and 8");
  end
  if (TIMER_W < 11) begin : g_timer_check
    $error("Timer too narrow for the longest conversion");
  end

  logic [7:0] control_q;
  logic [5:0] timing_q;
  logic [9:0] result_q;
  logic done_q;
  logic busy_q;
  sadc_state_e state_q;
  logic [7:0] wr_data;
  logic wr_lane;
  logic req;
  logic wr_ctl;
  logic wr_tim;
  logic rd_res;
  logic addr_ok;
  logic [15:0] len;
  logic len_ok;
  logic start_go;
  logic halt;
  logic expire;
  logic restart;
  sadc_mode_e mode;
  logic [1:0] wr_mode;
  logic sel_ctl;
  logic sel_tim;
  logic sel_res;
  logic mode_run;
  logic mode_repeat;
  logic chan_ok;
  logic store;
  logic [7:0] rd_byte;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign wr_lane = wb_sel_i[0];
  assign wr_data = wb_dat_i[7:0];
  assign wr_mode = wr_data[`SADC_CTL_MODE_HI:`SADC_CTL_MODE_LO];

  // Word index decode
  always_comb begin
    sel_ctl = 1'b0;
    sel_tim = 1'b0;
    sel_res = 1'b0;
    case (wb_adr_i[5:2])
      `SADC_IDX_CONTROL: begin
        sel_ctl = 1'b1;
      end
      `SADC_IDX_TIMING: begin
        sel_tim = 1'b1;
      end
      `SADC_IDX_RES_UPPER, `SADC_IDX_RES_LOWER: begin
        sel_res = 1'b1;
      end
      default: begin
        sel_ctl = 1'b0;
      end
    endcase
  end

  assign addr_ok = sel_ctl || sel_tim || sel_res;
  assign wr_ctl = req && wb_we_i && wr_lane && sel_ctl;
  assign wr_tim = req && wb_we_i && wr_lane && sel_tim;
  assign rd_res = req && !wb_we_i && sel_res;

  // Mode decode; the reserved code runs nothing
  assign mode = sadc_mode_e'(control_q[`SADC_CTL_MODE_HI:`SADC_CTL_MODE_LO]);
  always_comb begin
    mode_run = 1'b0;
    mode_repeat = 1'b0;
    case (mode)
      SADC_MODE_SINGLE: begin
        mode_run = 1'b1;
      end
      SADC_MODE_REPEAT: begin
        mode_run = 1'b1;
        mode_repeat = 1'b1;
      end
      default: begin
        mode_run = 1'b0;
      end
    endcase
  end

  // Channel codes at or above the channel count are reserved
  assign chan_ok = (int'(control_q[`SADC_CTL_CHAN_HI:`SADC_CTL_CHAN_LO]) < CHAN_N);

  // Start only in a valid mode with a valid channel and time code
  assign start_go = (state_q == SADC_ST_IDLE) && control_q[`SADC_CTL_START]
                 && mode_run && chan_ok && len_ok;
  assign halt = low_power_i || (wr_ctl && (wr_mode == 2'b00) && busy_q);
  assign restart = mode_repeat && chan_ok && len_ok;
  assign store = (state_q == SADC_ST_STORE);

  sadc_time_dec u_dec (
    .code_i(timing_q[`SADC_TIM_TIME_HI:`SADC_TIM_TIME_LO]),
    .cycles_o(len),
    .valid_o(len_ok)
  );

  sadc_timer #(.W(TIMER_W)) u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(start_go || (store && restart && !halt)),
    .abort_i(halt),
    .len_i(TIMER_W'(len)),
    .expire_o(expire)
  );

  // Control register
  always_ff @(posedge clk_i) begin
    if (rst_i || low_power_i) begin
      control_q <= `SADC_CONTROL_RST;
    end else if (wr_ctl) begin
      control_q <= wr_data;
    end else if (start_go) begin
      control_q[`SADC_CTL_START] <= 1'b0;
    end
  end

  // Timing register; fixed bits are kept as software writes them
  always_ff @(posedge clk_i) begin
    if (rst_i || low_power_i) begin
      timing_q <= `SADC_TIMING_RST;
    end else if (wr_tim) begin
      timing_q <= wr_data[5:0];
    end
  end

  // Sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i || halt) begin
      state_q <= SADC_ST_IDLE;
    end else begin
      case (state_q)
        SADC_ST_IDLE: begin
          if (start_go) begin
            state_q <= SADC_ST_CONV;
          end
        end
        SADC_ST_CONV: begin
          if (expire) begin
            state_q <= SADC_ST_STORE;
          end
        end
        SADC_ST_STORE: begin
          state_q <= restart ? SADC_ST_CONV : SADC_ST_IDLE;
        end
        default: state_q <= SADC_ST_IDLE;
      endcase
    end
  end

  // Busy flag
  always_ff @(posedge clk_i) begin
    if (rst_i || halt) begin
      busy_q <= 1'b0;
    end else if (start_go) begin
      busy_q <= 1'b1;
    end else if (state_q == SADC_ST_STORE && !restart) begin
      busy_q <= 1'b0;
    end
  end

  // Result is stored on expiry, before the done flag rises
  always_ff @(posedge clk_i) begin
    if (rst_i || low_power_i) begin
      result_q <= '0;
    end else if (state_q == SADC_ST_CONV && expire) begin
      result_q <= sample_data_i;
    end
  end

  // Done flag: set wins over read clear
  always_ff @(posedge clk_i) begin
    if (rst_i || low_power_i) begin
      done_q <= 1'b0;
    end else if (state_q == SADC_ST_STORE) begin
      done_q <= 1'b1;
    end else if (start_go || rd_res) begin
      done_q <= 1'b0;
    end
  end

  // Interrupt pulse alongside done flag
  always_ff @(posedge clk_i) begin
    if (rst_i || low_power_i) begin
      conv_done_irq_o <= 1'b0;
    end else begin
      conv_done_irq_o <= (state_q == SADC_ST_STORE);
    end
  end

  // Sample request pulse follows the capture edge
  always_ff @(posedge clk_i) begin
    if (rst_i || low_power_i) begin
      sample_req_o <= 1'b0;
    end else begin
      sample_req_o <= (state_q == SADC_ST_CONV) && expire;
    end
  end

  // Channel to the input multiplexer
  always_ff @(posedge clk_i) begin
    if (rst_i || low_power_i) begin
      channel_o <= 3'h0;
    end else begin
      channel_o <= control_q[2:0];
    end
  end

  // Inputs stay disabled out of reset
  always_ff @(posedge clk_i) begin
    if (rst_i || low_power_i) begin
      input_disable_o <= 1'b1;
    end else begin
      input_disable_o <= control_q[`SADC_CTL_INDIS];
    end
  end

  // Ladder current during conversion or always when asked
  always_ff @(posedge clk_i) begin
    if (rst_i || low_power_i) begin
      ladder_on_o <= 1'b0;
    end else begin
      ladder_on_o <= timing_q[`SADC_TIM_LADDER] || busy_q || start_go;
    end
  end

  // Busy seen by the analog side, including the start cycle
  always_ff @(posedge clk_i) begin
    if (rst_i || low_power_i) begin
      conv_busy_o <= 1'b0;
    end else begin
      conv_busy_o <= busy_q || start_go;
    end
  end

  // Read data of the addressed register
  always_comb begin
    rd_byte = 8'h00;
    case (wb_adr_i[5:2])
      `SADC_IDX_CONTROL: begin
        rd_byte = control_q;
      end
      `SADC_IDX_TIMING: begin
        rd_byte = {2'b00, timing_q};
      end
      `SADC_IDX_RES_UPPER: begin
        rd_byte = result_q[9:2];
      end
      `SADC_IDX_RES_LOWER: begin
        rd_byte = {result_q[1:0], done_q, busy_q, 4'h0};
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  // Wishbone ack one cycle after the request is taken
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req && addr_ok;
    end
  end

  // Unmapped index answers with err and has no effect
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_err_o <= 1'b0;
    end else begin
      wb_err_o <= req && !addr_ok;
    end
  end

  // Read data stands with ack only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && !wb_we_i) begin
      wb_dat_o <= {24'h00_0000, rd_byte};
    end else begin
      wb_dat_o <= 32'h0000_0000;
    end
  end
endmodule

// file: test/sadc_top_assertions.sv
// Port checker for the converter sequencer
`timescale 1ns/1ps
module sadc_top_assertions (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic low_power_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic sample_req_o,
  input wire logic [2:0] channel_o,
  input wire logic input_disable_o,
  input wire logic ladder_on_o,
  input wire logic conv_done_irq_o,
  input wire logic conv_busy_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_ctl_wr;
    wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && wb_ack_o && wb_adr_i[5:2] == 4'hE && !low_power_i;
  endsequence
  a_reset_state: assert property ($fell(rst_i) |-> input_disable_o && !conv_busy_o && !ladder_on_o)
    else $error("state after reset wrong");
  a_sleep_clears: assert property (low_power_i |=> input_disable_o && !conv_busy_o && !ladder_on_o)
    else $error("low power entry did not clear");
  a_start_runs: assert property (s_ctl_wr ##0 (wb_dat_i[7:5] inside {3'b101, 3'b111}
    && !wb_dat_i[3] && !conv_busy_o) |-> ##[1:3] conv_busy_o)
    else $error("start did not begin conversion");
  a_halt_stops: assert property (s_ctl_wr ##0 (wb_dat_i[6:5] == 2'b00) |-> ##[1:3] !conv_busy_o)
    else $error("disable did not halt");
  a_chan_follow: assert property (s_ctl_wr ##0 !wb_dat_i[3]
    |=> channel_o == $past(wb_dat_i[2:0]) && input_disable_o == $past(wb_dat_i[4]))
    else $error("channel or input control wrong");
  a_irq_pulse: assert property (conv_done_irq_o |=> !conv_done_irq_o)
    else $error("interrupt longer than one cycle");
  a_sample_busy: assert property (sample_req_o |-> $past(conv_busy_o, 2))
    else $error("sample without busy");
  a_sample_irq: assert property (sample_req_o |-> ##[0:3] conv_done_irq_o)
    else $error("no interrupt after sample");
endmodule
bind sadc_top sadc_top_assertions u_chk (.clk_i, .rst_i, .low_power_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .sample_req_o, .channel_o, .input_disable_o, .ladder_on_o,
  .conv_done_irq_o, .conv_busy_o);

// file: test/sadc_top_test.sv
// Self-checking bench of the converter sequencer
`timescale 1ns/1ps
module sadc_top_test;
  import sadc_pkg::*;
  typedef struct {logic we; logic [5:0] adr; logic [7:0] dat; logic [7:0] msk;} sadc_row_s;
  sadc_row_s rows[6] = '{'{0, 6'h38, 8'h10, 8'hFF}, '{0, 6'h3C, 8'h00, 8'h3F}, '{1, 6'h3C, 8'h14, 8'h00},
    '{0, 6'h3C, 8'h14, 8'h3F}, '{1, 6'h38, 8'h05, 8'h00}, '{0, 6'h38, 8'h05, 8'hFF}};
  logic [2:0] code[6] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
  int nlen[6] = '{39, 78, 156, 312, 624, 1248};
  int len[6];
  logic clk_i = 1'b0, rst_i = 1'b1, low_power_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [5:0] wb_adr_i = 6'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  sadc_result_t sample_data_i = 10'h000, res;
  logic wb_ack_o, wb_err_o, sample_req_o, input_disable_o, ladder_on_o, conv_done_irq_o, conv_busy_o, er;
  logic [2:0] channel_o;
  logic [7:0] rd;
  int errors = 0, checked = 0, cyc_n = 0, irqs = 0, reqs = 0, t0, n0;
  sadc_top u_dut (.clk_i, .rst_i, .low_power_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .wb_err_o, .sample_data_i, .sample_req_o, .channel_o, .input_disable_o, .ladder_on_o,
    .conv_done_irq_o, .conv_busy_o);
  always #10 clk_i = ~clk_i;
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc_n++;
    if (conv_done_irq_o === 1'b1) irqs++;
    if (sample_req_o === 1'b1) reqs++;
    if (cyc_n == 20000) begin
      errors++;
      report_and_stop();
    end
  end
  task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(logic w, logic [5:0] a, logic [7:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1) @(posedge clk_i);
    rd = wb_dat_o[7:0];
    er = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic wait_irq();
    @(posedge clk_i);
    while (conv_done_irq_o !== 1'b1) @(posedge clk_i);
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      bus(rows[i].we, rows[i].adr, rows[i].dat);
      if (!rows[i].we) check("register", rd & rows[i].msk, rows[i].dat & rows[i].msk);
    end
    check("channel", {channel_o, input_disable_o}, 4'hA);
    for (int i = 0; i < 6; i++) begin
      res = 10'h2C9 + 10'(i * 37);
      sample_data_i <= res;
      bus(1, 6'h3C, {4'b0001, code[i], 1'b0});
      t0 = cyc_n;
      n0 = irqs;
      bus(1, 6'h38, {3'b101, 2'b00, 3'(i)});
      repeat (3) @(posedge clk_i);
      check("ladder busy", ladder_on_o, 1'b1);
      wait_irq();
      len[i] = cyc_n - t0;
      check("length", len[i] - len[0], nlen[i] - 39);
      bus(0, 6'h38, 8'h00);
      check("start bit", rd, {3'b001, 2'b00, 3'(i)});
      bus(0, 6'h04, 8'h00);
      check("lower", rd & 8'hF0, {res[1:0], 2'b10, 4'h0});
      bus(0, 6'h00, 8'h00);
      check("upper", rd, res[9:2]);
      bus(0, 6'h04, 8'h00);
      check("done cleared", rd[5], 1'b0);
      repeat (60) @(posedge clk_i);
      check("single", {irqs - n0, conv_busy_o, ladder_on_o, channel_o}, {32'd1, 2'b00, 3'(i)});
    end
    bus(1, 6'h3C, 8'h10);
    sample_data_i <= 10'h155;
    n0 = irqs;
    bus(1, 6'h38, 8'hE2);
    while (irqs - n0 < 3) @(posedge clk_i);
    sample_data_i <= 10'h3AA;
    repeat (10) @(posedge clk_i);
    check("repeat busy", conv_busy_o, 1'b1);
    bus(1, 6'h38, 8'h02);
    repeat (5) @(posedge clk_i);
    n0 = irqs;
    repeat (100) @(posedge clk_i);
    bus(0, 6'h00, 8'h00);
    check("halted", {irqs - n0, conv_busy_o, rd}, {32'd0, 1'b0, 8'h55});
    bus(1, 6'h38, 8'hA2);
    wait_irq();
    sample_data_i <= 10'h0F0;
    bus(1, 6'h38, 8'hA2);
    bus(0, 6'h04, 8'h00);
    check("restart lower", rd & 8'hF0, 8'h90);
    bus(0, 6'h00, 8'h00);
    check("kept upper", rd, 8'hEA);
    wait_irq();
    bus(0, 6'h00, 8'h00);
    check("new upper", rd, 8'h3C);
    bus(1, 6'h3C, 8'h30);
    repeat (3) @(posedge clk_i);
    check("ladder on", ladder_on_o, 1'b1);
    bus(1, 6'h38, 8'hA2);
    repeat (10) @(posedge clk_i);
    low_power_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    low_power_i <= 1'b0;
    n0 = irqs;
    repeat (80) @(posedge clk_i);
    check("no resume", {irqs - n0, conv_busy_o, ladder_on_o}, 34'd0);
    bus(0, 6'h38, 8'h00);
    check("sleep control", rd, 8'h10);
    bus(0, 6'h3C, 8'h00);
    check("sleep timing", rd & 8'h3F, 8'h00);
    bus(0, 6'h14, 8'h00);
    check("unmapped", er, 1'b1);
    check("sample requests", reqs, irqs);
    report_and_stop();
  end
endmodule
